// >>> core/daqacr_pkg.sv
// Purpose: Shared constants and types for the acquisition control registers
// Assumes: 50 MHz reference clock, byte-wide register port
// Notes: Offsets are byte offsets from the board base
package daqacr_pkg;
  localparam logic [3:0] OFS_START = 4'h0;
  localparam logic [3:0] OFS_FIFO_HI = 4'h1;
  localparam logic [3:0] OFS_CHAN = 4'h2;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'h9;
  localparam logic [3:0] OFS_CFG = 4'hA;
  localparam logic [3:0] OFS_ANALOG = 4'hB;
  localparam logic [3:0] OFS_CAL_DATA = 4'hC;
  localparam logic [3:0] OFS_CAL_ADDR = 4'hD;
  localparam logic [3:0] OFS_CAL_CMD = 4'hE;
  localparam logic [3:0] OFS_KEY = 4'hF;
  localparam logic [7:0] EEPROM_KEY = 8'hA5;
  // Control register fields
  localparam int CTRL_AINT_BIT = 7;
  localparam int CTRL_TINT_BIT = 3;
  localparam int CTRL_HWEN_BIT = 1;
  localparam int CTRL_SEL_BIT = 0;
  localparam logic [7:0] CTRL_MASK = 8'h8B;
  // Configuration register fields
  localparam int CFG_CLR_BIT = 7;
  localparam int CFG_PAGE_BIT = 6;
  localparam int CFG_FIFO_MODE_ENABLE_BIT = 5;
  localparam int CFG_SCAN_BIT = 4;
  localparam int CFG_FRQ_BIT = 3;
  localparam int CFG_EXTG_BIT = 2;
  localparam int CFG_C0SRC_BIT = 1;
  localparam int CFG_C12G_BIT = 0;
  // Calibration command fields
  localparam int CAL_EE_GO_BIT = 7;
  localparam int CAL_EE_DIR_BIT = 6;
  localparam int CAL_RELOAD_BIT = 5;
  localparam int CAL_MUX_BIT = 4;
  localparam int CAL_TD_GO_BIT = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [6:0] CFG_RST = 7'h00;
  localparam logic [4:0] ANALOG_RST = 5'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int SETTLE_NS = 10000;
  localparam int SCAN_SLOW_NS = 9300;
  localparam int SCAN_FAST_NS = 5300;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SCAN_SLOW_CYC = (SCAN_SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int SCAN_FAST_CYC = (SCAN_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int DIV_10MHZ = CLK_MHZ / 10;
  localparam int DIV_1MHZ = CLK_MHZ;
  localparam int DIV_100KHZ = CLK_MHZ * 10;
  localparam int TMR_W = 10;

  typedef struct packed {
    logic scan_interval_select;
    logic range_select;
    logic polarity_select;
    logic gain_bit_high;
    logic gain_bit_low;
  } daqacr_analog_t;

  typedef struct packed {
    logic eeprom_transfer_go;
    logic eeprom_direction;
    logic calibration_reload;
    logic cal_mux_enable;
    logic trimdac_transfer_go;
  } daqacr_cal_t;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_GAP
  } daqacr_conv_t;
endpackage : daqacr_pkg

// >>> core/daqacr_regs.sv
// Purpose: Acquisition control register bank with sample FIFO
// Assumes: Bus strobes and inputs synchronous to i_ref_clk
// Notes: Read data is registered, valid one cycle after the read strobe
`timescale 1ns/1ps

module daqacr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_clear,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign o_in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;
  assign o_out_data = mem[rp_q];
  assign o_count = cnt_q;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wp_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (i_clear) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + AW'(1);
      if (pop) rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : daqacr_fifo

module daqacr_regs import daqacr_pkg::*; #(
  parameter int FIFO_DEPTH = 8,
  parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_single_ended,
  input wire logic i_adc_done,
  input wire logic [15:0] i_adc_data,
  output logic o_adc_start,
  output logic [3:0] o_adc_channel,
  output daqacr_analog_t o_analog_cfg,
  input wire logic i_digital_input_line0,
  input wire logic i_aux_input_line,
  input wire logic i_timer0_out,
  input wire logic i_pacer_out,
  output logic o_ctr0_clk,
  output logic o_ctr1_clk,
  output logic o_ctr12_gate,
  output logic o_ctr_wr,
  output logic o_ctr_rd,
  output logic [1:0] o_ctr_addr,
  output logic [7:0] o_ctr_wdata,
  input wire logic [7:0] i_ctr_rdata,
  output daqacr_cal_t o_cal_cmd,
  output logic [7:0] o_cal_wdata,
  output logic [7:0] o_cal_addr,
  input wire logic i_ee_rdata_valid,
  input wire logic [7:0] i_ee_rdata,
  input wire logic i_eeprom_busy,
  input wire logic i_trimdac_busy,
  output logic o_irq
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  initial begin
    if (FIFO_DEPTH < 4) $error("FIFO depth too small for byte pairs");
  end

  function automatic logic wr_at(input logic [3:0] a, input logic wr, input logic [3:0] ofs);
    wr_at = wr && (a == ofs);
  endfunction : wr_at

  logic [7:0] ctrl_q;
  logic [6:0] cfg_q;
  daqacr_analog_t analog_q;
  logic [7:0] chan_q;
  logic [3:0] cur_ch_q;
  logic [TMR_W-1:0] settle_q;
  logic ovf_q;
  logic unlock_q;
  logic [7:0] cal_data_q;
  logic [7:0] cal_addr_q;
  daqacr_cal_t cal_q;
  daqacr_conv_t state_q;
  logic [TMR_W-1:0] gap_q;
  logic msb_pend_q;
  logic [7:0] msb_q;
  logic [7:0] rdata_q;
  logic [7:0] last_byte_q;
  logic start_q;
  logic irq_q;
  logic tint_q;
  logic aint_q;
  logic digital_input_line0_q;
  logic aux_q;
  logic timer_q;
  logic pacer_q;
  logic [TMR_W-1:0] div1_q;
  logic [TMR_W-1:0] div0_q;
  logic ctr1_clk_q;
  logic ctr0_clk_q;
  logic ctr12_gate_q;
  logic ctr_wr_q;
  logic ctr_rd_q;
  logic [1:0] ctr_addr_q;
  logic [7:0] ctr_wdata_q;
  logic half_q;

  logic page1;
  logic upper;
  logic fifo_clear;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic [CW-1:0] fifo_count;
  logic fifo_pop;
  logic fifo_half;
  logic room2;
  logic trig;
  logic hw_trig;
  logic last_ch;
  logic conv_end;
  logic done_evt;

  assign page1 = cfg_q[CFG_PAGE_BIT];
  assign upper = i_addr[3] && i_addr[2];
  assign fifo_clear = wr_at(i_addr, i_wr, OFS_CFG) && i_wdata[CFG_CLR_BIT];
  assign fifo_half = (fifo_count >= CW'(FIFO_DEPTH / 2));
  assign room2 = (fifo_count <= CW'(FIFO_DEPTH - 2));
  assign fifo_pop = i_rd && (i_addr == OFS_START || i_addr == OFS_FIFO_HI);
  assign last_ch = (cur_ch_q == chan_q[7:4]);

  // Trigger sources
  assign hw_trig = ctrl_q[CTRL_SEL_BIT] ? (i_pacer_out && !pacer_q)
                 : (digital_input_line0_q && !i_digital_input_line0
                    && (!cfg_q[CFG_EXTG_BIT] || i_aux_input_line));
  assign trig = ctrl_q[CTRL_HWEN_BIT] ? hw_trig : wr_at(i_addr, i_wr, OFS_START);

  // Conversion ends after the last scan channel, or after one sample without scan
  assign conv_end = i_adc_done && (state_q == CONV_RUN) && (!cfg_q[CFG_SCAN_BIT] || last_ch);
  assign done_evt = conv_end;

  // FIFO feeding: LSB first, MSB next cycle
  assign fifo_in_valid = (i_adc_done && state_q == CONV_RUN && room2 && !ovf_q) || msb_pend_q;
  assign fifo_in_data = msb_pend_q ? msb_q : i_adc_data[7:0];

  daqacr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_clear(fifo_clear),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data),
    .o_count(fifo_count)
  );

  // Control register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_at(i_addr, i_wr, OFS_CTRL)) begin
      ctrl_q <= i_wdata & CTRL_MASK;
    end
  end

  // Configuration register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= CFG_RST;
    end else if (wr_at(i_addr, i_wr, OFS_CFG) && !i_wdata[CFG_CLR_BIT]) begin
      cfg_q <= i_wdata[6:0];
    end
  end

  // Analog configuration
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      analog_q <= ANALOG_RST;
    end else if (wr_at(i_addr, i_wr, OFS_ANALOG)) begin
      analog_q <= i_wdata[4:0];
    end
  end

  // Channel range and current channel
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chan_q <= CHAN_RST;
      cur_ch_q <= '0;
    end else if (wr_at(i_addr, i_wr, OFS_CHAN)) begin
      chan_q <= i_wdata;
      cur_ch_q <= i_wdata[3:0];
    end else if (i_adc_done && state_q == CONV_RUN) begin
      cur_ch_q <= last_ch ? chan_q[3:0] : cur_ch_q + 4'h1;
    end
  end

  // Settling timer
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      settle_q <= '0;
    end else if (wr_at(i_addr, i_wr, OFS_CHAN) || wr_at(i_addr, i_wr, OFS_ANALOG)) begin
      settle_q <= TMR_W'(SETTLE_CYC);
    end else if (settle_q != '0) begin
      settle_q <= settle_q - TMR_W'(1);
    end
  end

  // Conversion sequencer
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= CONV_IDLE;
      gap_q <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        CONV_IDLE: begin
          if (trig) begin
            state_q <= CONV_RUN;
            start_q <= 1'b1;
          end
        end
        CONV_RUN: begin
          if (conv_end) begin
            state_q <= CONV_IDLE;
          end else if (i_adc_done) begin
            state_q <= CONV_GAP;
            gap_q <= analog_q.scan_interval_select ? TMR_W'(SCAN_FAST_CYC - 2)
                                                   : TMR_W'(SCAN_SLOW_CYC - 2);
          end
        end
        CONV_GAP: begin
          if (gap_q == '0) begin
            state_q <= CONV_RUN;
            start_q <= 1'b1;
          end else begin
            gap_q <= gap_q - TMR_W'(1);
          end
        end
        default: state_q <= CONV_IDLE;
      endcase
    end
  end

  // FIFO byte pairing and overflow
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      msb_pend_q <= 1'b0;
      msb_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (msb_pend_q && fifo_in_ready) begin
        msb_pend_q <= 1'b0;
      end
      if (i_adc_done && state_q == CONV_RUN) begin
        if (room2 && !ovf_q) begin
          msb_pend_q <= 1'b1;
          msb_q <= i_adc_data[15:8];
        end else begin
          ovf_q <= 1'b1;
        end
      end else if (fifo_clear) begin
        ovf_q <= 1'b0;
      end
      if (fifo_clear) begin
        msb_pend_q <= 1'b0;
      end
    end
  end

  // Input edge history
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      digital_input_line0_q <= 1'b1;
      aux_q <= 1'b1;
      timer_q <= 1'b0;
      pacer_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      digital_input_line0_q <= i_digital_input_line0;
      aux_q <= i_aux_input_line;
      timer_q <= i_timer0_out;
      pacer_q <= i_pacer_out;
      half_q <= fifo_half;
    end
  end

  // Interrupt request flip-flop; a new event wins over the clear write
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aint_q <= 1'b0;
      tint_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      logic a_evt;
      logic t_evt;
      a_evt = 1'b0;
      t_evt = 1'b0;
      a_evt = ctrl_q[CTRL_AINT_BIT] && (cfg_q[CFG_FIFO_MODE_ENABLE_BIT] ? (fifo_half && !half_q) : done_evt);
      t_evt = ctrl_q[CTRL_TINT_BIT] && i_timer0_out && !timer_q;
      if (a_evt) aint_q <= 1'b1;
      else if (wr_at(i_addr, i_wr, OFS_IRQ_CLR)) aint_q <= 1'b0;
      if (t_evt) tint_q <= 1'b1;
      else if (wr_at(i_addr, i_wr, OFS_IRQ_CLR)) tint_q <= 1'b0;
      if (a_evt || t_evt) irq_q <= 1'b1;
      else if (wr_at(i_addr, i_wr, OFS_IRQ_CLR)) irq_q <= 1'b0;
    end
  end

  // Counter clocks and gates
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div1_q <= '0;
      div0_q <= '0;
      ctr1_clk_q <= 1'b0;
      ctr0_clk_q <= 1'b0;
      ctr12_gate_q <= 1'b1;
    end else begin
      ctr1_clk_q <= 1'b0;
      if (div1_q == '0) begin
        div1_q <= cfg_q[CFG_FRQ_BIT] ? TMR_W'(DIV_1MHZ - 1) : TMR_W'(DIV_10MHZ - 1);
        ctr1_clk_q <= 1'b1;
      end else begin
        div1_q <= div1_q - TMR_W'(1);
      end
      ctr0_clk_q <= 1'b0;
      if (cfg_q[CFG_C0SRC_BIT]) begin
        if (!i_aux_input_line) begin
          div0_q <= div0_q;
        end else if (div0_q == '0) begin
          div0_q <= TMR_W'(DIV_100KHZ - 1);
          ctr0_clk_q <= 1'b1;
        end else begin
          div0_q <= div0_q - TMR_W'(1);
        end
      end else begin
        ctr0_clk_q <= aux_q && !i_aux_input_line;
      end
      ctr12_gate_q <= cfg_q[CFG_C12G_BIT] ? i_digital_input_line0 : 1'b1;
    end
  end

  // Counter chip access on page 0
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctr_wr_q <= 1'b0;
      ctr_rd_q <= 1'b0;
      ctr_addr_q <= '0;
      ctr_wdata_q <= '0;
    end else begin
      ctr_wr_q <= i_wr && upper && !page1;
      ctr_rd_q <= i_rd && upper && !page1;
      if ((i_wr || i_rd) && upper && !page1) begin
        ctr_addr_q <= i_addr[1:0];
        ctr_wdata_q <= i_wdata;
      end
    end
  end

  // Calibration registers on page 1
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      unlock_q <= 1'b0;
      cal_data_q <= '0;
      cal_addr_q <= '0;
      cal_q <= '0;
    end else begin
      cal_q.eeprom_transfer_go <= 1'b0;
      cal_q.calibration_reload <= 1'b0;
      cal_q.trimdac_transfer_go <= 1'b0;
      if (wr_at(i_addr, i_wr, OFS_CFG) && !i_wdata[CFG_CLR_BIT] && i_wdata[CFG_PAGE_BIT]) begin
        unlock_q <= 1'b0;
      end else if (wr_at(i_addr, i_wr, OFS_KEY) && page1) begin
        unlock_q <= (i_wdata == EEPROM_KEY);
      end
      if (page1 && wr_at(i_addr, i_wr, OFS_CAL_DATA)) begin
        cal_data_q <= i_wdata;
      end else if (i_ee_rdata_valid) begin
        cal_data_q <= i_ee_rdata;
      end
      if (page1 && wr_at(i_addr, i_wr, OFS_CAL_ADDR)) begin
        cal_addr_q <= i_wdata;
      end
      if (page1 && wr_at(i_addr, i_wr, OFS_CAL_CMD)) begin
        cal_q.eeprom_transfer_go <= i_wdata[CAL_EE_GO_BIT] && unlock_q && !i_eeprom_busy;
        cal_q.eeprom_direction <= i_wdata[CAL_EE_DIR_BIT];
        cal_q.calibration_reload <= i_wdata[CAL_RELOAD_BIT];
        cal_q.cal_mux_enable <= i_wdata[CAL_MUX_BIT];
        cal_q.trimdac_transfer_go <= i_wdata[CAL_TD_GO_BIT] && !i_trimdac_busy;
      end
    end
  end

  // Register read mux
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= '0;
      last_byte_q <= '0;
    end else if (i_rd) begin
      case (i_addr)
        OFS_START, OFS_FIFO_HI: begin
          rdata_q <= fifo_out_valid ? fifo_out_data : last_byte_q;
          if (fifo_out_valid) last_byte_q <= fifo_out_data;
        end
        OFS_CHAN: rdata_q <= chan_q;
        OFS_IRQ_CLR: rdata_q <= {state_q != CONV_IDLE, tint_q, i_single_ended, aint_q, cur_ch_q};
        OFS_CTRL: rdata_q <= ctrl_q;
        OFS_CFG: rdata_q <= {settle_q != '0, cfg_q[6:3], ovf_q, fifo_half, !fifo_out_valid};
        OFS_ANALOG: rdata_q <= {cfg_q[2:0], 1'b0, analog_q[3:0]};
        OFS_CAL_DATA, OFS_CAL_ADDR, OFS_CAL_CMD, OFS_KEY: begin
          if (!page1) begin
            rdata_q <= i_ctr_rdata;
          end else begin
            case (i_addr[1:0])
              2'h0: rdata_q <= cal_data_q;
              2'h1: rdata_q <= cal_addr_q;
              2'h2: rdata_q <= {1'b0, i_trimdac_busy, i_eeprom_busy, cal_q.cal_mux_enable,
                                cal_q.trimdac_transfer_go, 3'h0};
              default: rdata_q <= REVISION;
            endcase
          end
        end
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign o_rdata = rdata_q;
  assign o_adc_start = start_q;
  assign o_adc_channel = cur_ch_q;
  assign o_analog_cfg = analog_q;
  assign o_ctr0_clk = ctr0_clk_q;
  assign o_ctr1_clk = ctr1_clk_q;
  assign o_ctr12_gate = ctr12_gate_q;
  assign o_ctr_wr = ctr_wr_q;
  assign o_ctr_rd = ctr_rd_q;
  assign o_ctr_addr = ctr_addr_q;
  assign o_ctr_wdata = ctr_wdata_q;
  assign o_cal_cmd = cal_q;
  assign o_cal_wdata = cal_data_q;
  assign o_cal_addr = cal_addr_q;
  assign o_irq = irq_q;
endmodule : daqacr_regs

// >>> tb/daqacr_regs_sva.sv
// Purpose: Port-level assertions for the register bank
// Assumes: Host writes are mirrored in shadow registers
// Notes: Bound to every daqacr_regs instance
`timescale 1ns/1ps
module daqacr_regs_chk import daqacr_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_adc_done,
  input wire logic o_adc_start,
  input wire logic [3:0] o_adc_channel,
  input wire daqacr_analog_t o_analog_cfg,
  input wire logic i_timer0_out,
  input wire logic i_aux_input_line,
  input wire logic o_ctr0_clk,
  input wire logic o_ctr1_clk,
  input wire logic o_ctr12_gate,
  input wire logic o_ctr_wr,
  input wire logic o_irq
);
  logic [7:0] ctl_q;
  logic [6:0] cfg_q;
  logic busy_q;
  logic [5:0] gap_q;
  logic [1:0] seen_q;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  // Shadow of control and configuration
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_q <= 8'h00;
      cfg_q <= 7'h00;
    end else if (i_wr && i_addr == OFS_CTRL) begin
      ctl_q <= i_wdata;
    end else if (i_wr && i_addr == OFS_CFG && !i_wdata[7]) begin
      cfg_q <= i_wdata[6:0];
    end
  end
  // Converter busy from start to done
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
    end else if (o_adc_start) begin
      busy_q <= 1'b1;
    end else if (i_adc_done) begin
      busy_q <= 1'b0;
    end
  end
  // Counter one tick spacing, settled after two ticks
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_q <= 6'h00;
      seen_q <= 2'h0;
    end else begin
      gap_q <= o_ctr1_clk ? 6'h00 : gap_q + 6'h01;
      if (i_wr && i_addr == OFS_CFG) begin
        seen_q <= 2'h0;
      end else if (o_ctr1_clk && seen_q != 2'h2) begin
        seen_q <= seen_q + 2'h1;
      end
    end
  end
  ctr_route_a: assert property (i_wr && i_addr[3:2] == 2'h3 |=> o_ctr_wr == (($past(cfg_q) & 7'h40) == 7'h00))
    else $error("counter strobe does not follow page");
  sw_start_a: assert property (o_adc_start && !ctl_q[1] && !cfg_q[4] |-> $past(i_wr) && $past(i_addr) == OFS_START)
    else $error("start without a start write");
  start_go_a: assert property (i_wr && i_addr == OFS_START && !ctl_q[1] && !busy_q && !o_adc_start |=> o_adc_start)
    else $error("start write did not start");
  timer_irq_a: assert property (ctl_q[3] && $rose(i_timer0_out) |-> ##[1:3] o_irq)
    else $error("timer event gave no interrupt");
  analog_cfg_a: assert property (i_wr && i_addr == OFS_ANALOG |=> {3'h0, o_analog_cfg} == ($past(i_wdata) & 8'h1F))
    else $error("analog setting not applied");
  chan_load_a: assert property (i_wr && i_addr == OFS_CHAN |=> {4'h0, o_adc_channel} == ($past(i_wdata) & 8'h0F))
    else $error("current channel not set to low channel");
  ctr1_rate_a: assert property (o_ctr1_clk && seen_q == 2'h2 |-> gap_q == (cfg_q[3] ? 6'h31 : 6'h04))
    else $error("counter one tick spacing wrong");
  gate_free_a: assert property ((!cfg_q[0]) [*3] |-> o_ctr12_gate)
    else $error("counters gated while free running");
  ctr0_edge_a: assert property (!cfg_q[1] && $fell(i_aux_input_line) |=> o_ctr0_clk)
    else $error("counter zero missed aux falling edge");
endmodule : daqacr_regs_chk

bind daqacr_regs daqacr_regs_chk chk_u (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
  .i_adc_done(i_adc_done), .o_adc_start(o_adc_start), .o_adc_channel(o_adc_channel),
  .o_analog_cfg(o_analog_cfg), .i_timer0_out(i_timer0_out), .o_ctr1_clk(o_ctr1_clk),
  .i_aux_input_line(i_aux_input_line), .o_ctr0_clk(o_ctr0_clk),
  .o_ctr12_gate(o_ctr12_gate), .o_ctr_wr(o_ctr_wr), .o_irq(o_irq)
);

// >>> tb/daqacr_adc_model.sv
// Purpose: Converter behind the register bank
// Assumes: One start at a time, answer after DLY cycles
// Notes: Data toggles outside the done cycle
`timescale 1ns/1ps
module daqacr_adc_model #(
  parameter int DLY = 20
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [3:0] i_channel,
  output logic o_done,
  output logic [15:0] o_data,
  output int o_starts
);
  int cnt_q;
  logic [3:0] ch_q;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 0;
      ch_q <= 4'h0;
      o_done <= 1'b0;
      o_data <= 16'h0000;
      o_starts <= 0;
    end else begin
      o_done <= (cnt_q == 1);
      o_data <= (cnt_q == 1) ? {8'hC3, 4'h0, ch_q} : ~o_data;
      if (i_start) begin
        cnt_q <= DLY;
        ch_q <= i_channel;
        o_starts <= o_starts + 1;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule : daqacr_adc_model

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Converter model answers each start after DLY cycles
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module testbench import daqacr_pkg::*; ;
  localparam int DLY = 20;
  localparam logic [7:0] REV = 8'h5E; // Arbitrary value
  logic i_ref_clk, i_nrst, wr_s, rd_s, adc_done, digital_input_line0, aux, tmr, pacer, ee_busy, td_busy, start, gate, irq;
  logic [1:0] caddr;
  logic [3:0] addr, chan;
  logic [7:0] wdata, rdata, cwdata;
  logic [15:0] adc_data;
  daqacr_analog_t acfg;
  daqacr_cal_t cal;
  int errors, compares, starts, ee_go, n;
  daqacr_regs #(.FIFO_DEPTH(8), .REVISION(REV)) dut_u (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(addr), .i_wr(wr_s), .i_rd(rd_s),
    .i_wdata(wdata), .o_rdata(rdata), .i_single_ended(1'b1), .i_adc_done(adc_done),
    .i_adc_data(adc_data), .o_adc_start(start), .o_adc_channel(chan), .o_analog_cfg(acfg),
    .i_digital_input_line0(digital_input_line0), .i_aux_input_line(aux), .i_timer0_out(tmr),
    .i_pacer_out(pacer), .o_ctr0_clk(), .o_ctr1_clk(), .o_ctr12_gate(gate), .o_ctr_wr(),
    .o_ctr_rd(), .o_ctr_addr(caddr), .o_ctr_wdata(cwdata), .i_ctr_rdata(8'h3C), .o_cal_cmd(cal),
    .o_cal_wdata(), .o_cal_addr(), .i_ee_rdata_valid(1'b0), .i_ee_rdata(8'h00),
    .i_eeprom_busy(ee_busy), .i_trimdac_busy(td_busy), .o_irq(irq)
  );
  daqacr_adc_model #(.DLY(DLY)) adc_u (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_start(start), .i_channel(chan),
    .o_done(adc_done), .o_data(adc_data), .o_starts(starts)
  );
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (cal.eeprom_transfer_go === 1'b1) ee_go++;
  end
  task automatic end_of_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    {wr_s, addr, wdata} = {1'b1, a, d};
    @(negedge i_ref_clk);
    wr_s = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(negedge i_ref_clk);
    {rd_s, addr} = {1'b1, a};
    @(negedge i_ref_clk);
    rd_s = 1'b0;
    @(negedge i_ref_clk);
    check(rdata, exp);
  endtask : rd
  task automatic wait_start(input int k);
    for (int i = 0; i < 200 && starts < k; i++) @(negedge i_ref_clk);
    if (starts < k) begin
      errors++;
      $display("CHECK FAILED t=%0t no conversion start", $time);
      end_of_test();
    end
    repeat (DLY + 3) @(negedge i_ref_clk);
  endtask : wait_start
  task automatic conv;
    n = starts;
    wr(4'h0, 8'h00);
    wait_start(n + 1);
  endtask : conv
  task automatic t_page;
    rd(4'hC, 8'h3C);
    wr(4'hD, 8'h5A);
    check(cwdata, 8'h5A);
    check({6'h00, caddr}, 8'h01);
    wr(4'hA, 8'h40);
    rd(4'hF, REV);
    rd(4'hA, 8'h41);
    wr(4'hF, EEPROM_KEY);
    ee_busy = 1'b1;
    rd(4'hE, 8'h20);
    td_busy = 1'b1;
    rd(4'hE, 8'h60);
    {ee_busy, td_busy} = 2'h0;
    wr(4'hE, 8'h80);
    wr(4'hA, 8'h40);
    wr(4'hE, 8'h80);
    check(8'(ee_go), 8'h01);
    wr(4'hA, 8'h00);
  endtask : t_page
  task automatic t_ctrl;
    wr(4'h9, 8'h80);
    rd(4'h9, 8'h80);
    wr(4'h9, 8'h08);
    rd(4'h9, 8'h08);
    tmr = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    check({7'h00, irq}, 8'h01);
    wr(4'h8, 8'h00);
    tmr = 1'b0;
    wr(4'h9, 8'h00);
    check({7'h00, irq}, 8'h00);
  endtask : t_ctrl
  task automatic t_cfg;
    wr(4'hA, 8'h38);
    wr(4'hA, 8'hC0);
    rd(4'hA, 8'h39);
    wr(4'hA, 8'h09);
    digital_input_line0 = 1'b0;
    repeat (200) @(negedge i_ref_clk);
    check({7'h00, gate}, 8'h00);
    digital_input_line0 = 1'b1;
    wr(4'hA, 8'h00);
    repeat (40) @(negedge i_ref_clk);
    check({7'h00, gate}, 8'h01);
  endtask : t_cfg
  task automatic t_settle;
    wr(4'hA, 8'h01);
    wr(4'hB, 8'h0B);
    rd(4'hB, 8'h2B);
    rd(4'hA, 8'h81);
    check({3'h0, acfg}, 8'h0B);
    repeat (SETTLE_CYC) @(negedge i_ref_clk);
    rd(4'hA, 8'h01);
  endtask : t_settle
  task automatic t_conv;
    wr(4'h2, 8'h21);
    repeat (SETTLE_CYC) @(negedge i_ref_clk);
    wr(4'h9, 8'h80);
    n = starts;
    wr(4'h0, 8'h00);
    rd(4'h8, 8'hA1);
    wait_start(n + 1);
    rd(4'h8, 8'h32);
    check({7'h00, irq}, 8'h01);
    rd(4'h0, 8'h01);
    rd(4'h1, 8'hC3);
    wr(4'h8, 8'h00);
    wr(4'h9, 8'h00);
    check({7'h00, irq}, 8'h00);
  endtask : t_conv
  task automatic t_hw;
    n = starts;
    wr(4'h9, 8'h02);
    wr(4'h0, 8'h00);
    repeat (40) @(negedge i_ref_clk);
    check(8'(starts - n), 8'h00);
    digital_input_line0 = 1'b0;
    wait_start(n + 1);
    digital_input_line0 = 1'b1;
    wr(4'hA, 8'h04);
    aux = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    digital_input_line0 = 1'b0;
    repeat (40) @(negedge i_ref_clk);
    check(8'(starts - n), 8'h01);
    {digital_input_line0, aux} = 2'h3;
    repeat (3) @(negedge i_ref_clk);
    digital_input_line0 = 1'b0;
    wait_start(n + 2);
    digital_input_line0 = 1'b1;
    wr(4'h9, 8'h03);
    pacer = 1'b1;
    wait_start(n + 3);
    pacer = 1'b0;
    wr(4'h9, 8'h00);
  endtask : t_hw
  task automatic t_ovf;
    wr(4'hA, 8'h80);
    rd(4'hA, 8'h01);
    repeat (5) conv();
    rd(4'hA, 8'h06);
    rd(4'h0, 8'h01);
    rd(4'hA, 8'h06);
    wr(4'hA, 8'h80);
    rd(4'hA, 8'h01);
  endtask : t_ovf
  initial begin
    {i_nrst, wr_s, rd_s, tmr, pacer, ee_busy, td_busy, addr, wdata} = '0;
    {digital_input_line0, aux} = 2'h3;
    {errors, compares, ee_go} = '0;
    repeat (20) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    rd(4'h9, 8'h00);
    rd(4'hB, 8'h00);
    t_page();
    t_ctrl();
    t_cfg();
    t_settle();
    t_conv();
    t_hw();
    t_ovf();
    end_of_test();
  end
endmodule : testbench
